/* File: src/vpdc_pkg.sv */
/*
  Package for the video power-down controller: register indices, field
  positions, reset values, mode encodings and timing constants.
  Assumes an indexed 8-bit register port on the host I/O side.
*/
package vpdc_pkg;

  // ************************************************************
  // register indices
  // ************************************************************
  localparam logic [7:0] VPDC_IDX_UNLOCK  = 8'h35; // map_ram_unlock_reg
  localparam logic [7:0] VPDC_IDX_POWER   = 8'h3A; // power_control_reg
  localparam logic [7:0] VPDC_IDX_REFRESH = 8'h3F; // powerdown_refresh_reg

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int VPDC_B_SLEEP  = 7;
  localparam int VPDC_B_DIV8   = 6;
  localparam int VPDC_B_HREL   = 5;
  localparam int VPDC_B_CBR    = 2;
  localparam int VPDC_B_WEIGHT = 1;
  localparam int VPDC_B_GPD_EN = 7;

  // readable mask of the power register while unlocked (bits 7..2)
  localparam logic [7:0] VPDC_RD_MASK_HI = 8'hFC;
  localparam logic [7:0] VPDC_RD_MASK_LO = 8'h03;
  // unlock pattern X011XXXX
  localparam logic [7:0] VPDC_UNLOCK_MASK = 8'h70;
  localparam logic [7:0] VPDC_UNLOCK_PAT  = 8'h30;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] VPDC_POWER_RST   = 8'h11; // reserved ones set
  localparam logic [7:0] VPDC_REFRESH_RST = 8'h00;
  localparam logic [7:0] VPDC_UNLOCK_RST  = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int         VPDC_DIV_RATIO   = 8;
  localparam logic [2:0] VPDC_DIV_LAST    = 3'h7;
  localparam int         VPDC_REF_FACTOR  = 8;
  localparam int         VPDC_REF_OFFSET  = 5;

  // ************************************************************
  // modes
  // ************************************************************
  typedef enum logic [4:0] {
    VPDC_M_RUN   = 5'h01,
    VPDC_M_SLEEP = 5'h02,
    VPDC_M_IDLE  = 5'h04,
    VPDC_M_GEXT  = 5'h08,
    VPDC_M_GINT  = 5'h10
  } vpdc_mode_e;

endpackage

/* File: src/vpdc_refresh_timer.sv */
/*
  Refresh period timer for general power-down: one pulse every
  8 x (period + 5) video clock ticks.
  Assumes video_tick is a one-cycle enable on ref_clk.
*/
`timescale 1ns/1ps
module vpdc_refresh_timer
  import vpdc_pkg::*;
#(
  parameter int CW = 11
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       video_tick,
  input  wire logic [6:0] period,
  output logic            refresh_pulse
);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          pulse;
  } vpdc_rt_s;

  vpdc_rt_s st_reg;
  vpdc_rt_s st_next;
  logic [CW-1:0] limit;

  // ************************************************************
  // period count
  // ************************************************************
  // period from field
  assign limit = CW'(VPDC_REF_FACTOR * (int'(period) + VPDC_REF_OFFSET) - 1);

  // next state
  always_comb begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    if (!enable) begin
      st_next.count = '0;
    end else if (video_tick) begin
      if (st_reg.count >= limit) begin
        st_next.count = '0;
        st_next.pulse = 1'b1;
      end else begin
        st_next.count = st_reg.count + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign refresh_pulse = st_reg.pulse;

endmodule // vpdc_refresh_timer

/* File: src/vpdc_power_ctrl.sv */
/*
  Power-down controller of a flat-panel display controller: control
  registers, mode decode, clock gating and divide-by-8 enables, refresh
  source and type, host access gating and host-release tristate.
  Assumes an indexed 8-bit register port, pins synchronised here.
*/
// What this block does
// - sleep with general power-down off stops clocks, refuses memory and I/O
// - in system power-down clocks are gated at the input
// - sleep and idle refresh is CAS-before-RAS from the refresh input pin
// - palette and map RAM contents lost after sleep; software reloads them
// - display idle divides clocks by 8, allows I/O, refuses memory
// - general power-down external clock runs undivided, all access allowed
// - general power-down internal clock divides by 8, all access allowed
// - general power-down refresh timed from seven-bit period field
// - general power-down refresh is RAS-only or CBR per type bit
// - bit 7 selects sleep, read back only while unlocked; 0 idle default, 1 system power-down
// - bit 6 divide select honoured only in general power-down, read back only while unlocked
// - host release bit and low pin ignore host cycles, tristate bus
// - every power-down keeps video memory, turns palette and panel off
// - bit 2 selects RAS-only when 0 default, CBR when 1
// - bit 1 enables colour-to-luminance weighting
// - bits 7..2 readable only while unlock register matches X011XXXX
// - refresh register bit 7 enables general power-down
// - refresh period is 8 video clocks times field plus five
`timescale 1ns/1ps
module vpdc_power_ctrl
  import vpdc_pkg::*;
#(
  parameter int DIV_RATIO = VPDC_DIV_RATIO
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // indexed register port
  input  wire logic [7:0] reg_index,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [7:0]      reg_rdata,
  // host cycle requests
  input  wire logic       host_mem_req,
  input  wire logic       host_io_req,
  output logic            host_mem_accept,
  output logic            host_io_accept,
  output logic            sys_bus_oe,
  // pins
  input  wire logic       powerdown_pin,
  input  wire logic       powerdown_refresh_input,
  input  wire logic       video_clock_tick,
  // clock enables and status
  output logic            memory_clock_en,
  output logic            video_clock_en,
  output logic            refresh_req,
  output logic            refresh_cbr,
  output logic            palette_out_en,
  output logic            panel_out_en,
  output logic            weighting_en,
  output logic            palette_reload_needed,
  output logic            in_powerdown
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] power;
    logic [7:0] refresh;
    logic [7:0] unlock;
    logic [7:0] rdata;
    logic [2:0] div_cnt;
    logic [2:0] vtick_div;  // video edges within a divided clock
    logic [1:0] pin_sync;
    logic [1:0] pref_sync;
    logic [1:0] vtick_sync;
    logic       pref_last;
    logic       vtick_last;
    logic       reload;
  } vpdc_st_s;

  vpdc_st_s   st_reg;
  vpdc_st_s   st_next;
  vpdc_mode_e mode;
  logic       released;
  logic       div_pulse;
  logic       timer_pulse;
  logic       vtick_rise;
  logic       timer_tick;
  logic       unlocked;
  logic       vtick_wrap;

  // divide terminal count from the ratio parameter
  localparam logic [2:0] DIV_LAST = 3'(DIV_RATIO - 1);

  // unlock pattern check
  function automatic logic vpdc_is_unlocked(input logic [7:0] v);
    return (v & VPDC_UNLOCK_MASK) == VPDC_UNLOCK_PAT;
  endfunction

  // ************************************************************
  // mode decode
  // ************************************************************
  // combinational decode
  always_comb begin
    if (st_reg.refresh[VPDC_B_GPD_EN]) begin
      mode = st_reg.power[VPDC_B_DIV8] ? VPDC_M_GINT : VPDC_M_GEXT;
    end else begin
      mode = st_reg.power[VPDC_B_SLEEP] ? VPDC_M_SLEEP : VPDC_M_IDLE;
    end
  end

  // ************************************************************
  // derived strobes
  // ************************************************************
  // one cycle strobes from the synchronised pins and the dividers
  assign unlocked   = vpdc_is_unlocked(st_reg.unlock);
  assign vtick_rise = st_reg.vtick_sync[1] & ~st_reg.vtick_last;
  assign div_pulse  = (st_reg.div_cnt == DIV_LAST);
  // last video edge of each divided video clock
  assign vtick_wrap = vtick_rise & (st_reg.vtick_div == DIV_LAST);

  // another controller owns the bus once the release bit is set and the synced pin is low
  // host release
  assign released = st_reg.power[VPDC_B_HREL] & ~st_reg.pin_sync[1];

  // ************************************************************
  // clocks and refresh
  // ************************************************************
  always_comb begin
    memory_clock_en = 1'b1;
    video_clock_en  = 1'b1;
    timer_tick      = 1'b0;
    refresh_req     = 1'b0;
    // pin driven refresh is always cas before ras
    refresh_cbr     = 1'b1;
    case (mode)
      VPDC_M_SLEEP: begin
        memory_clock_en = 1'b0;
        video_clock_en  = 1'b0;
        refresh_req = st_reg.pref_sync[1] & ~st_reg.pref_last;
      end
      VPDC_M_IDLE: begin
        memory_clock_en = div_pulse;
        video_clock_en  = div_pulse;
        refresh_req = st_reg.pref_sync[1] & ~st_reg.pref_last;
      end
      VPDC_M_GEXT: begin
        // the system has already slowed both clocks
        // undivided clocks
        timer_tick  = vtick_rise;
        refresh_req = timer_pulse;
        refresh_cbr = st_reg.power[VPDC_B_CBR];
      end
      VPDC_M_GINT: begin
        memory_clock_en = div_pulse;
        video_clock_en  = div_pulse;
        // timer counts divided video clocks, not raw edges
        timer_tick      = vtick_wrap;
        refresh_req = timer_pulse;
        refresh_cbr = st_reg.power[VPDC_B_CBR];
      end
      default: begin
        memory_clock_en = 1'b1;
        video_clock_en  = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // access gating
  // ************************************************************
  // release overrides the mode: the bus belongs to someone else
  always_comb begin
    host_mem_accept = 1'b0;
    host_io_accept  = 1'b0;
    case (mode)
      VPDC_M_SLEEP: begin
        host_mem_accept = 1'b0;
        host_io_accept  = 1'b0;
      end
      VPDC_M_IDLE: begin
        host_io_accept = host_io_req;
      end
      default: begin
        host_mem_accept = host_mem_req;
        host_io_accept  = host_io_req;
      end
    endcase
    if (released) begin
      host_mem_accept = 1'b0;
      host_io_accept  = 1'b0;
    end
  end

  assign sys_bus_oe = ~released;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next            = st_reg;
    // pins cross into this clock through two flip-flops
    st_next.pin_sync   = {st_reg.pin_sync[0], powerdown_pin};
    st_next.pref_sync  = {st_reg.pref_sync[0], powerdown_refresh_input};
    st_next.vtick_sync = {st_reg.vtick_sync[0], video_clock_tick};
    st_next.pref_last  = st_reg.pref_sync[1];
    st_next.vtick_last = st_reg.vtick_sync[1];
    // divide counter free-runs so a mode change keeps its phase
    st_next.div_cnt    = st_reg.div_cnt + 3'h1;
    // count video edges for the internal divide-by-8 video clock
    if (vtick_rise) begin
      st_next.vtick_div = st_reg.vtick_div + 3'h1;
    end
    if (mode == VPDC_M_SLEEP) begin
      st_next.reload = 1'b1;
    end
    // host writes are lost while the bus is released
    if (reg_write && !released) begin
      case (reg_index)
        VPDC_IDX_UNLOCK:  st_next.unlock  = reg_wdata;
        VPDC_IDX_POWER: begin
          st_next.power = reg_wdata;
          // sleep keeps setting the flag, so its set wins
          if (mode != VPDC_M_SLEEP) begin
            st_next.reload = 1'b0;
          end
        end
        VPDC_IDX_REFRESH: st_next.refresh = reg_wdata;
        default: ;
      endcase
    end
    // read data is registered and answers one cycle later
    if (reg_read && !released) begin
      case (reg_index)
        VPDC_IDX_UNLOCK:  st_next.rdata = st_reg.unlock;
        VPDC_IDX_POWER:   st_next.rdata = unlocked ? st_reg.power
                              : (st_reg.power & VPDC_RD_MASK_LO);
        VPDC_IDX_REFRESH: st_next.rdata = st_reg.refresh;
        default:          st_next.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg         <= '0;
      st_reg.power   <= VPDC_POWER_RST;
      st_reg.refresh <= VPDC_REFRESH_RST;
      st_reg.unlock  <= VPDC_UNLOCK_RST;
      // pin synchroniser starts at the idle-high level: no release
      st_reg.pin_sync <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // refresh timer
  // ************************************************************
  // timer holds cleared while general power-down is off
  // period from field
  vpdc_refresh_timer u_timer (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .enable        (st_reg.refresh[VPDC_B_GPD_EN]),
    .video_tick    (timer_tick),
    .period        (st_reg.refresh[6:0]),
    .refresh_pulse (timer_pulse)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata    = st_reg.rdata;
  assign weighting_en = st_reg.power[VPDC_B_WEIGHT];
  // the block only exists while a power-down mode is active
  // outputs off in power-down
  assign in_powerdown   = 1'b1;
  assign palette_out_en = 1'b0;
  assign panel_out_en   = 1'b0;
  assign palette_reload_needed = st_reg.reload;

endmodule // vpdc_power_ctrl

/* File: sim/vpdc_power_ctrl_asserts.sv */
/*
  Checker for the power-down controller: mode, clock, access, refresh
  and read-back relations. Assumes only the top module's ports.
*/
`timescale 1ns/1ps
module vpdc_power_ctrl_asserts
  import vpdc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       host_mem_req,
  input wire logic       host_io_req,
  input wire logic       host_mem_accept,
  input wire logic       host_io_accept,
  input wire logic       sys_bus_oe,
  input wire logic       powerdown_pin,
  input wire logic       memory_clock_en,
  input wire logic       video_clock_en,
  input wire logic       refresh_req,
  input wire logic       refresh_cbr,
  input wire logic       palette_out_en,
  input wire logic       panel_out_en,
  input wire logic       weighting_en,
  input wire logic       in_powerdown
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] pw_q, unl_q;
  logic       gpd_q, p1, p2;
  wire        rel = pw_q[VPDC_B_HREL] && !p2;
  wire        div = gpd_q ? pw_q[VPDC_B_DIV8] : !pw_q[VPDC_B_SLEEP];
  wire        unl = (unl_q & VPDC_UNLOCK_MASK) == VPDC_UNLOCK_PAT;
  wire [7:0]  exp_rd = unl ? pw_q : (pw_q & VPDC_RD_MASK_LO);
  // shadow of the registers as writes land
  always_ff @(posedge ref_clk) begin
    p1 <= powerdown_pin;
    p2 <= p1;
    if (rst) begin
      pw_q  <= VPDC_POWER_RST;
      unl_q <= VPDC_UNLOCK_RST;
      gpd_q <= 1'b0;
    end else if (reg_write && !rel) begin
      if (reg_index == VPDC_IDX_POWER) pw_q <= reg_wdata;
      if (reg_index == VPDC_IDX_UNLOCK) unl_q <= reg_wdata;
      if (reg_index == VPDC_IDX_REFRESH) gpd_q <= reg_wdata[7];
    end
  end
  a_sleep_stops_all: assert property (!gpd_q && pw_q[7] |->
    !memory_clock_en && !video_clock_en && !host_mem_accept
    && !host_io_accept) else $error("sleep left clock or access on");
  a_idle_io_only: assert property (!gpd_q && !pw_q[7] && host_io_req
    && !rel |-> host_io_accept && !host_mem_accept)
    else $error("idle access gating wrong");
  a_ext_clock_full: assert property (gpd_q && !pw_q[6] |->
    memory_clock_en && video_clock_en) else $error("clock not full rate");
  a_divide_spacing: assert property (div && memory_clock_en |=>
    (!memory_clock_en || !div)[*7]) else $error("divide spacing wrong");
  a_pin_refresh_cbr: assert property (refresh_req && !gpd_q |->
    refresh_cbr) else $error("pin refresh not cas before ras");
  a_gpd_refresh_type: assert property (refresh_req && gpd_q |->
    refresh_cbr == pw_q[VPDC_B_CBR]) else $error("refresh type wrong");
  a_host_release: assert property ((pw_q[5] && !powerdown_pin)[*4]
    |-> !sys_bus_oe && !host_mem_accept && !host_io_accept)
    else $error("release did not float bus");
  a_outputs_off: assert property (!palette_out_en && !panel_out_en
    && in_powerdown) else $error("palette or panel output on");
  a_power_read: assert property (reg_read && !rel &&
    reg_index == VPDC_IDX_POWER |=> reg_rdata == $past(exp_rd))
    else $error("power register read wrong");
  a_weight_bit: assert property (weighting_en == pw_q[1])
    else $error("weighting enable wrong");
endmodule // vpdc_power_ctrl_asserts

bind vpdc_power_ctrl vpdc_power_ctrl_asserts u_chk (.ref_clk, .rst,
  .reg_index, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .host_mem_req, .host_io_req, .host_mem_accept, .host_io_accept,
  .sys_bus_oe, .powerdown_pin, .memory_clock_en, .video_clock_en,
  .refresh_req, .refresh_cbr, .palette_out_en, .panel_out_en,
  .weighting_en, .in_powerdown);

/* File: sim/vpdc_far_model.sv */
/*
  Far-side model: free-running video clock level and a refresh request
  pin pulsed on demand. Assumes the bench raises fire for one cycle.
*/
`timescale 1ns/1ps
module vpdc_far_model (
  input  wire logic ref_clk,
  input  wire logic fire,
  output logic      powerdown_refresh_input,
  output logic      video_clock_tick
);
  logic [2:0] hold = 3'h0;
  initial begin
    powerdown_refresh_input = 1'b0;
    video_clock_tick        = 1'b0;
  end
  // video clock level toggles every cycle
  always @(negedge ref_clk) video_clock_tick <= ~video_clock_tick;
  always @(posedge ref_clk) begin
    if (fire) hold <= 3'h4;
    else if (hold != 3'h0) hold <= hold - 3'h1;
    powerdown_refresh_input <= fire || (hold > 3'h1);
  end
endmodule // vpdc_far_model

/* File: sim/test_video_power_down_control.sv */
/*
  Testbench for the power-down controller: register tasks, mode table,
  refresh, release and read-back. Assumes the far model and checker.
*/
`timescale 1ns/1ps
module test_video_power_down_control import vpdc_pkg::*;;
  logic       ref_clk, rst, reg_write, reg_read, fire, powerdown_pin;
  logic       host_mem_req, host_io_req, host_mem_accept, host_io_accept;
  logic       sys_bus_oe, refresh_req, refresh_cbr, in_powerdown;
  logic       powerdown_refresh_input, video_clock_tick, weighting_en;
  logic       memory_clock_en, video_clock_en, palette_reload_needed;
  logic       palette_out_en, panel_out_en;
  logic [7:0] reg_index, reg_wdata, reg_rdata, n_m, n_v;
  int         fail_count = 0, tests_run = 0, cyc = 0, rc = 0, t0;
  logic [7:0] t_ref[7] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
  logic [7:0] t_pw[7]  = '{8'h91, 8'h11, 8'h11, 8'h51, 8'h91, 8'hD1, 8'hD1};
  logic [7:0] t_n[7]   = '{8'h00, 8'h01, 8'h08, 8'h01, 8'h08, 8'h01, 8'h00};
  logic [7:0] t_acc[7] = '{8'h00, 8'h01, 8'h03, 8'h03, 8'h03, 8'h03, 8'h00};

  vpdc_power_ctrl u_dut (.ref_clk, .rst, .reg_index, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .host_mem_req, .host_io_req,
    .host_mem_accept, .host_io_accept, .sys_bus_oe, .powerdown_pin,
    .powerdown_refresh_input, .video_clock_tick, .memory_clock_en,
    .video_clock_en, .refresh_req, .refresh_cbr, .palette_out_en,
    .panel_out_en, .weighting_en, .palette_reload_needed, .in_powerdown);
  vpdc_far_model u_far (.ref_clk, .fire, .powerdown_refresh_input,
    .video_clock_tick);

  // clock, refresh pulse count and hang limit
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (refresh_req === 1'b1) rc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge ref_clk);
    reg_index = i;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    @(negedge ref_clk);
    reg_index = i;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    chk(reg_rdata, e);
  endtask
  // counts clock enables over eight cycles
  task automatic cnt8();
    n_m = 8'h00;
    n_v = 8'h00;
    repeat (8) begin
      @(negedge ref_clk);
      n_m += {7'h00, memory_clock_en};
      n_v += {7'h00, video_clock_en};
    end
  endtask
  task automatic wait_ref();
    int n;
    n = rc;
    repeat (1000) if (rc == n) @(negedge ref_clk);
  endtask
  function automatic logic [7:0] acc();
    return {5'h00, sys_bus_oe, host_mem_accept, host_io_accept};
  endfunction

  initial begin
    {reg_write, reg_read, fire, host_mem_req, host_io_req} = 5'h00;
    reg_index = 8'h00;
    reg_wdata = 8'h00;
    powerdown_pin = 1'b1;
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    host_mem_req = 1'b1;
    host_io_req = 1'b1;
    rd(VPDC_IDX_POWER, 8'h01);
    chk(acc(), 8'h05);
    // every mode, with the don't-care bits both ways except bit 6 in idle
    for (int i = 0; i < 7; i++) begin
      wr(VPDC_IDX_REFRESH, t_ref[i]);
      wr(VPDC_IDX_POWER, t_pw[i]);
      cnt8();
      chk(n_m, t_n[i]);
      chk(n_v, t_n[i]);
      chk(acc() & 8'h03, t_acc[i]);
    end
    chk({7'h00, palette_reload_needed}, 8'h01);
    wr(VPDC_IDX_POWER, 8'h11);
    wr(VPDC_IDX_POWER, 8'h11);
    chk({7'h00, palette_reload_needed}, 8'h00);
    // idle: one pin request gives one refresh, no timer pulses
    t0 = rc;
    fire = 1'b1;
    @(negedge ref_clk);
    fire = 1'b0;
    repeat (100) @(negedge ref_clk);
    chk(8'(rc - t0), 8'h01);
    chk({7'h00, refresh_cbr}, 8'h01);
    // general power-down refresh period for two field values
    for (int z = 0; z < 4; z += 2) begin
      wr(VPDC_IDX_REFRESH, 8'(8'h80 + z));
      wr(VPDC_IDX_POWER, z ? 8'h11 : 8'h15);
      chk({7'h00, refresh_cbr}, z ? 8'h00 : 8'h01);
      wait_ref();
      t0 = cyc;
      wait_ref();
      chk(8'(cyc - t0), 8'(16 * (z + 5)));
    end
    // internal divide: the timer counts divided video clocks
    wr(VPDC_IDX_REFRESH, 8'h80);
    wr(VPDC_IDX_POWER, 8'h55);
    wait_ref();
    t0 = cyc;
    wait_ref();
    chk(16'(cyc - t0), 16'h0280);
    // read-back lock, unlock pattern and unmapped index
    wr(VPDC_IDX_POWER, 8'h17);
    chk({7'h00, weighting_en}, 8'h01);
    wr(VPDC_IDX_UNLOCK, 8'h70);
    rd(VPDC_IDX_POWER, 8'h03);
    wr(VPDC_IDX_UNLOCK, 8'hB0);
    rd(VPDC_IDX_POWER, 8'h17);
    rd(8'h20, 8'h00);
    // host release floats the bus and ignores writes
    wr(VPDC_IDX_POWER, 8'h31);
    powerdown_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(acc(), 8'h00);
    wr(VPDC_IDX_POWER, 8'h11);
    powerdown_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(acc(), 8'h07);
    rd(VPDC_IDX_POWER, 8'h31);
    conclude();
  end
endmodule // test_video_power_down_control
